// File: hw/bstp_chain.sv
// boundary-scan cell chain: capture/shift stage and update stage
`timescale 1ns/10ps
`default_nettype none
module bstp_chain #(
    parameter int LEN = bstp_pkg::BSR_LEN_DEF
) (
    // clock and reset
    input wire logic tck,
    input wire logic rst,
    // control
    input wire logic cap_en,
    input wire logic shift_en,
    input wire logic upd_en,
    // serial path
    input wire logic si,
    output logic so,
    // parallel data
    input wire logic [LEN-1:0] cap_d,
    output logic [LEN-1:0] upd_q
);

    logic [LEN-1:0] sr_q;

    // ------------------------------------------------------------
    // capture and shift stage
    // ------------------------------------------------------------
    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            sr_q <= '0;
        end else if (cap_en) begin
            sr_q <= cap_d;
        end else if (shift_en) begin
            sr_q <= {si, sr_q[LEN-1:1]};
        end
    end

    assign so = sr_q[0];

    // ------------------------------------------------------------
    // update stage holds the pattern driven on the pins
    // ------------------------------------------------------------
    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            upd_q <= '0;
        end else if (upd_en) begin
            upd_q <= sr_q;
        end
    end

    chain_capture_a: assert property (
        @(posedge tck) disable iff (rst) cap_en |=> sr_q == $past(cap_d))
        else $error("chain did not capture pin states");

    chain_update_a: assert property (
        @(posedge tck) disable iff (rst)
        upd_en ##1 !upd_en[*2] |-> upd_q == $past(sr_q, 2))
        else $error("chain update stage not held");

endmodule
`default_nettype wire

// File: hw/bstp_pkg.sv
// constants and types shared by the boundary-scan test port
package bstp_pkg;

    // ------------------------------------------------------------
    // register widths
    // ------------------------------------------------------------
    localparam int IR_W = 10;
    localparam int ID_W = 32;
    localparam int UC_W = 32;
    localparam int UC_USER_W = 7;
    localparam int UC_FIX_W = 25;
    localparam int CFG_W = 8;
    localparam int CFG_CNT_W = 3;
    localparam int BSR_LEN_DEF = 690;

    // ------------------------------------------------------------
    // instruction codes and capture pattern
    // ------------------------------------------------------------
    localparam logic [IR_W-1:0] IR_EXTEST = 10'h000;
    localparam logic [IR_W-1:0] IR_CFG_LOAD = 10'h002;
    localparam logic [IR_W-1:0] IR_SAMPLE = 10'h005;
    localparam logic [IR_W-1:0] IR_IDCODE = 10'h006;
    localparam logic [IR_W-1:0] IR_USERCODE = 10'h007;
    localparam logic [IR_W-1:0] IR_BYPASS = 10'h3ff;
    localparam logic [IR_W-1:0] IR_CAPTURE = 10'h001;
    localparam logic [1:0] IR_CAP_LSB = 2'h1;
    localparam logic [CFG_CNT_W-1:0] CFG_LAST = 3'h7;

    // ------------------------------------------------------------
    // identity and signature defaults (values arbitrary)
    // ------------------------------------------------------------
    localparam logic [3:0] ID_VER_DEF = 4'h3;
    localparam logic [15:0] ID_PART_DEF = 16'h5a5a;
    localparam logic [10:0] ID_MFR_DEF = 11'h2b3;
    localparam logic [UC_FIX_W-1:0] UC_FIXED_DEF = 25'h0abcdef;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        S_TLR, S_RTI, S_SEL_DR, S_CAP_DR, S_SH_DR, S_EX1_DR, S_PA_DR,
        S_EX2_DR, S_UPD_DR, S_SEL_IR, S_CAP_IR, S_SH_IR, S_EX1_IR,
        S_PA_IR, S_EX2_IR, S_UPD_IR
    } bstp_state_e;

    typedef enum logic [2:0] {
        DR_BYPASS, DR_ID, DR_USER, DR_BSR, DR_CFG
    } bstp_dr_e;

endpackage

// File: hw/bstp_tap.sv
// boundary-scan test access port with configuration instructions
`timescale 1ns/10ps
`default_nettype none
// Function
// - ten-bit instruction register shifts tdi to tdo
// - no boundary testing while configuration runs
// - sample/preload captures pins, preloads pattern
// - extest drives update values, captures inputs
// - bypass is one-bit, one-stage delay
// - usercode instruction shifts user signature out
// - signature: seven user bits, 25 fixed
// - idcode instruction shifts identification out
// - id fields: version, part, maker, one
// - id lsb is one, shifted first
// - configuration bytes loaded through test port
// - chain length is a variant parameter
// - undriven tms and tdi read high
module bstp_tap #(
    parameter int BSR_LEN = bstp_pkg::BSR_LEN_DEF,
    parameter logic [3:0] ID_VER = bstp_pkg::ID_VER_DEF,
    parameter logic [15:0] ID_PART = bstp_pkg::ID_PART_DEF,
    parameter logic [10:0] ID_MFR = bstp_pkg::ID_MFR_DEF,
    parameter logic [bstp_pkg::UC_FIX_W-1:0] UC_FIXED =
        bstp_pkg::UC_FIXED_DEF
) (
    // system clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // test port
    input wire logic tck,
    input wire logic tms_in,
    input wire logic tms_drv,
    input wire logic tdi_in,
    input wire logic tdi_drv,
    output logic tdo,
    output logic tdo_oe,
    // device pins and core
    input wire logic [BSR_LEN-1:0] core_out,
    input wire logic [BSR_LEN-1:0] pin_in,
    output logic [BSR_LEN-1:0] pin_out,
    // configuration engine
    input wire logic cfg_busy,
    input wire logic [bstp_pkg::UC_USER_W-1:0] user_bits,
    output logic [bstp_pkg::CFG_W-1:0] cfg_byte,
    output logic cfg_valid,
    output logic cfg_active
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    bstp_pkg::bstp_state_e state_q, state_d;
    bstp_pkg::bstp_dr_e dr_sel;
    logic rst_tck_m, rst_tck_q;
    logic tms_eff, tdi_eff;
    logic busy_m, busy_s;
    logic [bstp_pkg::UC_USER_W-1:0] user_m, user_s;
    logic [BSR_LEN-1:0] pin_m, pin_s;
    logic [bstp_pkg::IR_W-1:0] ir_sh_q, ir_q;
    logic bypass_q;
    logic [bstp_pkg::ID_W-1:0] dr32_q;
    logic [bstp_pkg::CFG_W-1:0] cfg_sh_q, cfg_hold_q;
    logic [bstp_pkg::CFG_CNT_W-1:0] cfg_cnt_q;
    logic cfg_tgl_q;
    logic chain_so, extest_tck, cfg_tck;
    logic [BSR_LEN-1:0] chain_upd;
    logic dr_out;
    logic shift_dr, shift_ir, cap_dr;
    logic ext_m, ext_s;
    logic act_m;
    logic tgl_m, tgl_s, tgl_d;
    logic [BSR_LEN-1:0] upd_s;
    logic upd_tgl_q, ut_m, ut_s, ut_d;
    logic tdo_q, tdo_oe_q;
    logic [bstp_pkg::CFG_W-1:0] cfg_byte_q;
    logic cfg_valid_q, cfg_active_q;
    logic [BSR_LEN-1:0] pin_out_q;

    // ------------------------------------------------------------
    // instruction decode, shared by path select and checks
    // ------------------------------------------------------------
    function automatic bstp_pkg::bstp_dr_e dr_decode(
        input logic [bstp_pkg::IR_W-1:0] ir,
        input logic busy
    );
        dr_decode = bstp_pkg::DR_BYPASS;
        if (ir == bstp_pkg::IR_IDCODE) begin
            dr_decode = bstp_pkg::DR_ID;
        end else if (ir == bstp_pkg::IR_USERCODE) begin
            dr_decode = bstp_pkg::DR_USER;
        end else if (ir == bstp_pkg::IR_CFG_LOAD) begin
            dr_decode = bstp_pkg::DR_CFG;
        end else if ((ir == bstp_pkg::IR_EXTEST ||
                      ir == bstp_pkg::IR_SAMPLE) && !busy) begin
            dr_decode = bstp_pkg::DR_BSR;
        end
    endfunction

    // ------------------------------------------------------------
    // reset into the test clock domain
    // ------------------------------------------------------------
    always_ff @(posedge tck or posedge sys_rst) begin
        if (sys_rst) begin
            rst_tck_m <= 1'b1;
            rst_tck_q <= 1'b1;
        end else begin
            rst_tck_m <= 1'b0;
            rst_tck_q <= rst_tck_m;
        end
    end

    // ------------------------------------------------------------
    // port inputs and crossings into the test clock domain
    // ------------------------------------------------------------
    assign tms_eff = tms_drv ? tms_in : 1'b1;
    assign tdi_eff = tdi_drv ? tdi_in : 1'b1;

    always_ff @(posedge tck or posedge rst_tck_q) begin
        if (rst_tck_q) begin
            busy_m <= 1'b0;
            busy_s <= 1'b0;
            user_m <= '0;
            user_s <= '0;
            pin_m <= '0;
            pin_s <= '0;
        end else begin
            busy_m <= cfg_busy;
            busy_s <= busy_m;
            user_m <= user_bits;
            user_s <= user_m;
            pin_m <= pin_in;
            pin_s <= pin_m;
        end
    end

    // ------------------------------------------------------------
    // controller
    // ------------------------------------------------------------
    always_comb begin
        unique case (state_q)
            bstp_pkg::S_TLR:
                state_d = tms_eff ? bstp_pkg::S_TLR : bstp_pkg::S_RTI;
            bstp_pkg::S_RTI:
                state_d = tms_eff ? bstp_pkg::S_SEL_DR : bstp_pkg::S_RTI;
            bstp_pkg::S_SEL_DR:
                state_d = tms_eff ? bstp_pkg::S_SEL_IR : bstp_pkg::S_CAP_DR;
            bstp_pkg::S_CAP_DR:
                state_d = tms_eff ? bstp_pkg::S_EX1_DR : bstp_pkg::S_SH_DR;
            bstp_pkg::S_SH_DR:
                state_d = tms_eff ? bstp_pkg::S_EX1_DR : bstp_pkg::S_SH_DR;
            bstp_pkg::S_EX1_DR:
                state_d = tms_eff ? bstp_pkg::S_UPD_DR : bstp_pkg::S_PA_DR;
            bstp_pkg::S_PA_DR:
                state_d = tms_eff ? bstp_pkg::S_EX2_DR : bstp_pkg::S_PA_DR;
            bstp_pkg::S_EX2_DR:
                state_d = tms_eff ? bstp_pkg::S_UPD_DR : bstp_pkg::S_SH_DR;
            bstp_pkg::S_UPD_DR:
                state_d = tms_eff ? bstp_pkg::S_SEL_DR : bstp_pkg::S_RTI;
            bstp_pkg::S_SEL_IR:
                state_d = tms_eff ? bstp_pkg::S_TLR : bstp_pkg::S_CAP_IR;
            bstp_pkg::S_CAP_IR:
                state_d = tms_eff ? bstp_pkg::S_EX1_IR : bstp_pkg::S_SH_IR;
            bstp_pkg::S_SH_IR:
                state_d = tms_eff ? bstp_pkg::S_EX1_IR : bstp_pkg::S_SH_IR;
            bstp_pkg::S_EX1_IR:
                state_d = tms_eff ? bstp_pkg::S_UPD_IR : bstp_pkg::S_PA_IR;
            bstp_pkg::S_PA_IR:
                state_d = tms_eff ? bstp_pkg::S_EX2_IR : bstp_pkg::S_PA_IR;
            bstp_pkg::S_EX2_IR:
                state_d = tms_eff ? bstp_pkg::S_UPD_IR : bstp_pkg::S_SH_IR;
            bstp_pkg::S_UPD_IR:
                state_d = tms_eff ? bstp_pkg::S_SEL_DR : bstp_pkg::S_RTI;
        endcase
    end

    always_ff @(posedge tck or posedge rst_tck_q) begin
        if (rst_tck_q) begin
            state_q <= bstp_pkg::S_TLR;
        end else begin
            state_q <= state_d;
        end
    end

    assign shift_dr = (state_q == bstp_pkg::S_SH_DR);
    assign shift_ir = (state_q == bstp_pkg::S_SH_IR);
    assign cap_dr = (state_q == bstp_pkg::S_CAP_DR);

    // ------------------------------------------------------------
    // instruction register
    // ------------------------------------------------------------
    always_ff @(posedge tck or posedge rst_tck_q) begin
        if (rst_tck_q) begin
            ir_sh_q <= bstp_pkg::IR_CAPTURE;
            ir_q <= bstp_pkg::IR_IDCODE;
        end else begin
            if (state_q == bstp_pkg::S_CAP_IR) begin
                ir_sh_q <= bstp_pkg::IR_CAPTURE;
            end else if (shift_ir) begin
                ir_sh_q <= {tdi_eff, ir_sh_q[bstp_pkg::IR_W-1:1]};
            end
            if (state_q == bstp_pkg::S_TLR) begin
                ir_q <= bstp_pkg::IR_IDCODE;
            end else if (state_q == bstp_pkg::S_UPD_IR) begin
                ir_q <= ir_sh_q;
            end
        end
    end

    assign dr_sel = dr_decode(ir_q, busy_s);
    assign extest_tck = (ir_q == bstp_pkg::IR_EXTEST) && !busy_s;
    assign cfg_tck = (dr_sel == bstp_pkg::DR_CFG);

    // ------------------------------------------------------------
    // bypass, identification and signature paths
    // ------------------------------------------------------------
    always_ff @(posedge tck or posedge rst_tck_q) begin
        if (rst_tck_q) begin
            bypass_q <= 1'b0;
        end else if (cap_dr) begin
            bypass_q <= 1'b0;
        end else if (shift_dr) begin
            bypass_q <= tdi_eff;
        end
    end

    always_ff @(posedge tck or posedge rst_tck_q) begin
        if (rst_tck_q) begin
            dr32_q <= '0;
        end else if (cap_dr && dr_sel == bstp_pkg::DR_ID) begin
            dr32_q <= {ID_VER, ID_PART, ID_MFR, 1'b1};
        end else if (cap_dr && dr_sel == bstp_pkg::DR_USER) begin
            dr32_q <= {UC_FIXED, user_s};
        end else if (shift_dr) begin
            dr32_q <= {tdi_eff, dr32_q[bstp_pkg::ID_W-1:1]};
        end
    end

    // ------------------------------------------------------------
    // configuration byte loader
    // ------------------------------------------------------------
    always_ff @(posedge tck or posedge rst_tck_q) begin
        if (rst_tck_q) begin
            cfg_sh_q <= '0;
            cfg_cnt_q <= '0;
            cfg_hold_q <= '0;
            cfg_tgl_q <= 1'b0;
        end else if (cap_dr) begin
            cfg_cnt_q <= '0;
        end else if (shift_dr && cfg_tck) begin
            cfg_sh_q <= {tdi_eff, cfg_sh_q[bstp_pkg::CFG_W-1:1]};
            cfg_cnt_q <= cfg_cnt_q + 3'h1;
            if (cfg_cnt_q == bstp_pkg::CFG_LAST) begin
                cfg_hold_q <= {tdi_eff, cfg_sh_q[bstp_pkg::CFG_W-1:1]};
                cfg_tgl_q <= !cfg_tgl_q;
            end
        end
    end

    // ------------------------------------------------------------
    // boundary chain
    // ------------------------------------------------------------
    bstp_chain #(
        .LEN(BSR_LEN)
    ) bstp_chain_i (
        .tck(tck),
        .rst(rst_tck_q),
        .cap_en(cap_dr && dr_sel == bstp_pkg::DR_BSR),
        .shift_en(shift_dr && dr_sel == bstp_pkg::DR_BSR),
        .upd_en(state_q == bstp_pkg::S_UPD_DR &&
                dr_sel == bstp_pkg::DR_BSR),
        .si(tdi_eff),
        .so(chain_so),
        .cap_d(pin_s),
        .upd_q(chain_upd)
    );

    // toggle marks a new pattern in the update stage for the pin side
    always_ff @(posedge tck or posedge rst_tck_q) begin
        if (rst_tck_q) begin
            upd_tgl_q <= 1'b0;
        end else if (state_q == bstp_pkg::S_UPD_DR &&
                     dr_sel == bstp_pkg::DR_BSR) begin
            upd_tgl_q <= !upd_tgl_q;
        end
    end

    // ------------------------------------------------------------
    // serial output, changes on the falling edge
    // ------------------------------------------------------------
    always_comb begin
        unique case (dr_sel)
            bstp_pkg::DR_BYPASS: dr_out = bypass_q;
            bstp_pkg::DR_ID: dr_out = dr32_q[0];
            bstp_pkg::DR_USER: dr_out = dr32_q[0];
            bstp_pkg::DR_BSR: dr_out = chain_so;
            bstp_pkg::DR_CFG: dr_out = cfg_sh_q[0];
            default: dr_out = bypass_q;
        endcase
    end

    always_ff @(negedge tck or posedge rst_tck_q) begin
        if (rst_tck_q) begin
            tdo_q <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else begin
            tdo_q <= shift_ir ? ir_sh_q[0] : dr_out;
            tdo_oe_q <= shift_ir || shift_dr;
        end
    end

    assign tdo = tdo_q;
    assign tdo_oe = tdo_oe_q;

    // ------------------------------------------------------------
    // crossings into the system clock domain
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ext_m <= 1'b0;
            ext_s <= 1'b0;
            ut_m <= 1'b0;
            ut_s <= 1'b0;
            ut_d <= 1'b0;
            upd_s <= '0;
            act_m <= 1'b0;
            cfg_active_q <= 1'b0;
            tgl_m <= 1'b0;
            tgl_s <= 1'b0;
            tgl_d <= 1'b0;
        end else begin
            ext_m <= extest_tck;
            ext_s <= ext_m;
            ut_m <= upd_tgl_q;
            ut_s <= ut_m;
            ut_d <= ut_s;
            // pattern is stable for several test clocks after its toggle
            if (ut_s ^ ut_d) begin
                upd_s <= chain_upd;
            end
            act_m <= cfg_tck;
            cfg_active_q <= act_m;
            tgl_m <= cfg_tgl_q;
            tgl_s <= tgl_m;
            tgl_d <= tgl_s;
        end
    end

    // pins follow the core unless extest owns them
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_out_q <= '0;
        end else begin
            pin_out_q <= ext_s ? upd_s : core_out;
        end
    end

    // byte is stable for eight test clocks after its toggle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_byte_q <= '0;
            cfg_valid_q <= 1'b0;
        end else begin
            cfg_valid_q <= tgl_s ^ tgl_d;
            if (tgl_s ^ tgl_d) begin
                cfg_byte_q <= cfg_hold_q;
            end
        end
    end

    assign pin_out = pin_out_q;
    assign cfg_byte = cfg_byte_q;
    assign cfg_valid = cfg_valid_q;
    assign cfg_active = cfg_active_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence five_high_s;
        tms_eff [*5];
    endsequence

    sequence ir_load_s;
        state_q == bstp_pkg::S_CAP_IR ##1 shift_ir;
    endsequence

    ir_capture_a: assert property (
        @(posedge tck) disable iff (rst_tck_q)
        state_q == bstp_pkg::S_CAP_IR |=> ir_sh_q[1:0] ==
            bstp_pkg::IR_CAP_LSB)
        else $error("ir capture pattern wrong");

    ir_width_a: assert property (
        @(posedge tck) disable iff (rst_tck_q)
        ir_load_s |=> ir_sh_q == {$past(tdi_eff),
            bstp_pkg::IR_CAPTURE[bstp_pkg::IR_W-1:1]})
        else $error("ir not ten bits of tdi");

    tap_reset_a: assert property (
        @(posedge tck) disable iff (rst_tck_q)
        five_high_s |=> state_q == bstp_pkg::S_TLR ##1
            (ir_q == bstp_pkg::IR_IDCODE))
        else $error("five tms highs did not reset");

    bypass_stage_a: assert property (
        @(posedge tck) disable iff (rst_tck_q)
        shift_dr && dr_sel == bstp_pkg::DR_BYPASS |=>
            bypass_q == $past(tdi_eff))
        else $error("bypass delay not one stage");

    id_lsb_a: assert property (
        @(posedge tck) disable iff (rst_tck_q)
        cap_dr && dr_sel == bstp_pkg::DR_ID |=> dr32_q[0] &&
            dr32_q[31:28] == ID_VER)
        else $error("id capture wrong");

    user_fixed_a: assert property (
        @(posedge tck) disable iff (rst_tck_q)
        cap_dr && dr_sel == bstp_pkg::DR_USER |=>
            dr32_q == {UC_FIXED, $past(user_s)})
        else $error("user signature wrong");

    busy_block_a: assert property (
        @(posedge tck) disable iff (rst_tck_q)
        busy_s |-> dr_sel != bstp_pkg::DR_BSR && !extest_tck)
        else $error("boundary path open during configuration");

    tdo_enable_a: assert property (
        @(posedge tck) disable iff (rst_tck_q)
        tdo_oe_q == (shift_ir || shift_dr) &&
            (!shift_ir || tdo_q == ir_sh_q[0]))
        else $error("tdo enable outside shift");

    cfg_toggle_a: assert property (
        @(posedge tck) disable iff (rst_tck_q)
        shift_dr && cfg_tck && cfg_cnt_q == bstp_pkg::CFG_LAST |=>
            cfg_tgl_q != $past(cfg_tgl_q) && cfg_cnt_q == '0)
        else $error("config byte not handed over");

endmodule
`default_nettype wire

// File: testbench/bstp_host.sv
// test controller model that drives the boundary-scan test port
`timescale 1ns/10ps
`default_nettype none
module bstp_host (
    // test port
    output logic tck,
    output logic tms_in,
    output logic tms_drv,
    output logic tdi_in,
    output logic tdi_drv,
    input wire logic tdo
);
    logic flt;
    initial begin
        tck = 1'b0;
        tms_in = 1'b1;
        tms_drv = 1'b1;
        tdi_in = 1'b1;
        tdi_drv = 1'b1;
        flt = 1'b0;
    end
    // one test clock; tck stays low between calls
    task automatic step(input logic m, input logic d, output logic o);
        tms_drv = !flt;
        tdi_drv = !flt;
        tms_in = flt ? !tms_in : m;
        tdi_in = flt ? !tdi_in : d;
        #6;
        o = tdo;
        tck = 1'b1;
        #6;
        tck = 1'b0;
    endtask
endmodule
`default_nettype wire

// File: testbench/test_boundary_scan_tap_port.sv
// self-checking bench for the boundary-scan test port
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_mismatch++; \
    $display("MISMATCH t=%0t got %0h exp %0h", $time, a, e); end end
module test_boundary_scan_tap_port;
    logic clk, sys_rst, cfg_busy, cfg_valid, cfg_active, tdo, tdo_oe;
    logic tck, tms_in, tms_drv, tdi_in, tdi_drv, o;
    logic [15:0] core_out, pin_in, pin_out;
    logic [6:0] user_bits;
    logic [7:0] cfg_byte;
    logic [31:0] d;
    int n_mismatch, check_count, cyc;
    bstp_host bstp_host_i (.tck(tck), .tms_in(tms_in), .tms_drv(tms_drv),
        .tdi_in(tdi_in), .tdi_drv(tdi_drv), .tdo(tdo));
    bstp_tap #(.BSR_LEN(16)) bstp_tap_i (.clk(clk), .sys_rst(sys_rst),
        .tck(tck), .tms_in(tms_in), .tms_drv(tms_drv), .tdi_in(tdi_in),
        .tdi_drv(tdi_drv), .tdo(tdo), .tdo_oe(tdo_oe),
        .core_out(core_out), .pin_in(pin_in), .pin_out(pin_out),
        .cfg_busy(cfg_busy), .user_bits(user_bits), .cfg_byte(cfg_byte),
        .cfg_valid(cfg_valid), .cfg_active(cfg_active));
    initial begin
        clk = 1'b0;
        forever #2 clk = !clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            summarize();
        end
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic pins(input logic [15:0] c, input logic [15:0] p,
                        input logic b);
        @(negedge clk);
        core_out = c;
        pin_in = p;
        cfg_busy = b;
        repeat (8) @(negedge clk);
    endtask
    // ------------------------------------------------------------
    // scan from run-test/idle back to run-test/idle
    // ------------------------------------------------------------
    task automatic scan(input bit ir, input int n, input logic [31:0] din);
        d = '0;
        bstp_host_i.step(1, 1, o);
        if (ir)
            bstp_host_i.step(1, 1, o);
        bstp_host_i.step(0, 1, o);
        bstp_host_i.step(0, 1, o);
        for (int i = 0; i < n; i++) begin
            bstp_host_i.step(i == n - 1, din[i], o);
            d[i] = o;
            if (i == 0) `CHK(tdo_oe, 1'b1)
        end
        bstp_host_i.step(1, 1, o);
        bstp_host_i.step(0, 1, o);
        `CHK(tdo_oe, 1'b0)
    endtask
    task automatic t_idcode();
        scan(0, 32, 32'h0);
        `CHK(d, {bstp_pkg::ID_VER_DEF, bstp_pkg::ID_PART_DEF, bstp_pkg::ID_MFR_DEF, 1'b1})
        `CHK(d[0], 1'b1)
    endtask
    task automatic t_ir_bypass();
        scan(1, 10, 32'(bstp_pkg::IR_BYPASS));
        `CHK(d[9:0], bstp_pkg::IR_CAPTURE)
        `CHK(d[1:0], bstp_pkg::IR_CAP_LSB)
        scan(0, 9, 32'h0b5);
        `CHK(d[8:0], 9'h16a)
    endtask
    task automatic t_user();
        scan(1, 10, 32'(bstp_pkg::IR_USERCODE));
        scan(0, 32, 32'h0);
        `CHK(d, {bstp_pkg::UC_FIXED_DEF, 7'h55})
    endtask
    task automatic t_boundary();
        pins(16'h0f0f, 16'h1234, 1'b0);
        scan(1, 10, 32'(bstp_pkg::IR_SAMPLE));
        scan(0, 16, 32'h7e81);
        `CHK(d[15:0], 16'h1234)
        pins(16'h0f0f, 16'h3c96, 1'b0);
        `CHK(pin_out, 16'h0f0f)
        scan(1, 10, 32'(bstp_pkg::IR_EXTEST));
        pins(16'h0f0f, 16'h3c96, 1'b0);
        `CHK(pin_out, 16'h7e81)
        scan(0, 16, 32'ha55a);
        `CHK(d[15:0], 16'h3c96)
        pins(16'h0f0f, 16'h3c96, 1'b0);
        `CHK(pin_out, 16'ha55a)
    endtask
    task automatic t_busy();
        pins(16'hc3c3, 16'h3c96, 1'b1);
        scan(0, 16, 32'h00ff);
        `CHK(d[15:0], 16'h01fe)
        pins(16'hc3c3, 16'h3c96, 1'b1);
        `CHK(pin_out, 16'hc3c3)
        pins(16'hc3c3, 16'h3c96, 1'b0);
    endtask
    task automatic t_cfg();
        logic seen;
        logic [7:0] b;
        seen = 1'b0;
        b = '0;
        scan(1, 10, 32'(bstp_pkg::IR_CFG_LOAD));
        pins(16'hc3c3, 16'h3c96, 1'b0);
        `CHK(cfg_active, 1'b1)
        fork
            scan(0, 8, 32'ha6);
            for (int k = 0; k < 200 && !seen; k++) begin
                @(posedge clk);
                #1;
                if (cfg_valid === 1'b1) begin
                    seen = 1'b1;
                    b = cfg_byte;
                end
            end
        join
        `CHK(seen, 1'b1)
        `CHK(b, 8'ha6)
    endtask
    task automatic t_float();
        bstp_host_i.flt = 1'b1;
        repeat (5) bstp_host_i.step(0, 0, o);
        bstp_host_i.flt = 1'b0;
        bstp_host_i.step(0, 1, o);
        t_idcode();
        `CHK(cfg_active, 1'b0)
    endtask
    initial begin
        sys_rst = 1'b1;
        cfg_busy = 1'b0;
        core_out = '0;
        pin_in = '0;
        user_bits = 7'h55;
        fork
            repeat (8) @(negedge clk);
            repeat (3) bstp_host_i.step(1, 1, o);
        join
        sys_rst = 1'b0;
        repeat (5) bstp_host_i.step(1, 1, o);
        bstp_host_i.step(0, 1, o);
        t_idcode();
        t_ir_bypass();
        t_user();
        t_boundary();
        t_busy();
        t_cfg();
        t_float();
        summarize();
    end
endmodule
`default_nettype wire
